// ==== rtl/spa_regs.svh ====
// Constants shared by both ends of the phase-align and receive output link.
// Assumes it is included by its bare name from the package and modules.
`ifndef SPA_REGS_SVH
`define SPA_REGS_SVH

// ============================================================
// Link shape
`define SPA_NCH            4
`define SPA_CW             10

// ============================================================
// Static configuration bundle carried over the link
`define SPA_CFG_CKSEL_LSB  0
`define SPA_CFG_RATE_BIT   2
`define SPA_CFG_RX_CLOCK_RATE_SELECT_BIT 3
`define SPA_CFG_PAR_LSB    4
`define SPA_CFG_FCHAR_LSB  6
`define SPA_CFG_RFEN_LSB   8
`define SPA_CFG_W          12

// ============================================================
// Timing
`define SPA_CLK_NS         10
`define SPA_REF_HALF       3'd6
`define SPA_RX_HALF_FULL   3'd2
`define SPA_RX_HALF_HALF   3'd4
`define SPA_ALIGN_MIN_EDGES 2
`define SPA_PULSE_EDGES    2'd3
`define SPA_TX_LOCK_NS     10000
`define SPA_TX_LOCK_CYC    ((`SPA_TX_LOCK_NS + `SPA_CLK_NS - 1) / `SPA_CLK_NS)

// ============================================================
// Transmit PLL multipliers and framing patterns
`define SPA_MUL_FULL       5'd10
`define SPA_MUL_HALF       5'd20
`define SPA_COMMA_NEG      7'h1f
`define SPA_K285_NEG       10'h0fa

// ============================================================
// Host buffering
`define SPA_FIFO_DEPTH     16
`define SPA_FIFO_W         48

`endif

// ==== rtl/spa_pkg.sv ====
// Types shared by both ends of the phase-align and receive output link.
// Assumes spa_regs.svh is on the include path.
`include "spa_regs.svh"

package spa_pkg;

  // ============================================================
  // Three-level static selects
  typedef enum logic [1:0] {
    TRI_LOW  = 2'b00,
    TRI_MID  = 2'b01,
    TRI_HIGH = 2'b10
  } spa_tri_t;

  // ============================================================
  // Transmit phase-align buffer state
  typedef enum logic [1:0] {
    AL_BYPASS = 2'b00,
    AL_LOCK   = 2'b01,
    AL_RETUNE = 2'b10
  } spa_align_t;

  // ============================================================
  // Host initialisation sequence
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_LOCK  = 2'b01,
    H_PULSE = 2'b10,
    H_DONE  = 2'b11
  } spa_host_st_t;

  typedef struct packed {
    logic [`SPA_CFG_W-1:0]                  cfg_s1;
    logic [`SPA_CFG_W-1:0]                  cfg_s2;
    logic                                   ref_s1;
    logic                                   ref_s2;
    logic                                   ref_s3;
    logic                                   rst_s1;
    logic                                   rst_s2;
    logic [1:0]                             low_cnt;
    spa_align_t                             align;
    logic [3:0]                             phase;
    logic                                   slip;
    logic                                   fault;
    logic [4:0]                             mult;
    logic [2:0]                             rx_div;
    logic                                   rclk;
    logic                                   take;
    logic [`SPA_NCH-1:0][`SPA_CW-1:0]       prev;
    logic [`SPA_NCH-1:0][3:0]               offset;
    logic [`SPA_NCH-1:0][`SPA_CW-1:0]       data;
    logic [`SPA_NCH-1:0]                    flag;
    logic [`SPA_NCH-1:0]                    par;
  } spa_dev_state_t;

  typedef struct packed {
    logic [2:0]                             ref_div;
    logic                                   ref_clk;
    spa_host_st_t                           st;
    logic [15:0]                            cnt;
    logic [1:0]                             edges;
    logic                                   rst_n;
    logic                                   t_s1;
    logic                                   t_s2;
    logic                                   t_s3;
    logic                                   c_s1;
    logic                                   c_s2;
    logic                                   c_s3;
    logic [`SPA_FIFO_W-1:0]                 w_s1;
    logic [`SPA_FIFO_W-1:0]                 w_s2;
    logic                                   overrun;
  } spa_host_state_t;

endpackage : spa_pkg

// ==== rtl/spa_link_if.sv ====
// Pins between the transceiver end and the host end.
// Assumes the bench joins both modports; no clocking is implied here.
`include "spa_regs.svh"

interface spa_link_if;
  logic                               reference_clock_in;
  logic                               tx_phase_align_reset_n;
  logic [`SPA_CFG_W-1:0]              cfg_pins;
  logic [`SPA_NCH-1:0][`SPA_CW-1:0]   rx_data_word;
  logic [`SPA_NCH-1:0]                frame_char_detect_flag;
  logic [`SPA_NCH-1:0]                rx_odd_parity_out;
  logic [`SPA_NCH-1:0]                rx_odd_parity_oe;
  logic [`SPA_NCH-1:0]                recovered_char_clock_pair_t;
  logic [`SPA_NCH-1:0]                recovered_char_clock_pair_c;

  modport dev (
    input  reference_clock_in,
    input  tx_phase_align_reset_n,
    input  cfg_pins,
    output rx_data_word,
    output frame_char_detect_flag,
    output rx_odd_parity_out,
    output rx_odd_parity_oe,
    output recovered_char_clock_pair_t,
    output recovered_char_clock_pair_c
  );

  modport host (
    output reference_clock_in,
    output tx_phase_align_reset_n,
    output cfg_pins,
    input  rx_data_word,
    input  frame_char_detect_flag,
    input  rx_odd_parity_out,
    input  rx_odd_parity_oe,
    input  recovered_char_clock_pair_t,
    input  recovered_char_clock_pair_c
  );
endinterface : spa_link_if

// ==== rtl/spa_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock and a synchronous active-high reset.

module spa_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic         core_clk,
  input  wire logic         reset,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW:0]  wr_q;
  logic [AW:0]  rd_q;
  logic         push;
  logic         pop;

  assign in_ready  = (wr_q - rd_q) != (AW + 1)'(D);
  assign out_valid = wr_q != rd_q;
  assign out_data  = mem_q[rd_q[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end
endmodule : spa_fifo

// ==== rtl/spa_dev.sv ====
// Transceiver end: transmit phase-align control and receive output port.
// Assumes the host end drives the link pins from another clock domain.
`include "spa_regs.svh"

module spa_dev
  import spa_pkg::*;
(
  input  wire logic                             core_clk,
  input  wire logic                             reset,
  spa_link_if.dev                               link,
  input  wire logic [`SPA_NCH-1:0][`SPA_CW-1:0] rx_raw_chars,
  output logic                                  rx_raw_take,
  input  wire logic                             tx_buffer_fault_in,
  output logic                                  tx_aligned,
  output logic                                  tx_char_slip,
  output logic [3:0]                            tx_phase_offset,
  output logic                                  tx_buffer_fault_flag,
  output logic [4:0]                            tx_pll_multiplier
);

  // ============================================================
  // Helpers

  // Framing match against both disparities of the selected pattern.
  function automatic logic frame_match(input logic [`SPA_CW-1:0] w,
                                       input spa_tri_t sel);
    logic hit;
    hit = 1'b0;
    case (sel)
      TRI_MID: begin
        hit = (w[9:3] == `SPA_COMMA_NEG) || (w[9:3] == ~`SPA_COMMA_NEG);
      end
      TRI_HIGH: begin
        hit = (w == `SPA_K285_NEG) || (w == ~`SPA_K285_NEG);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    return hit;
  endfunction : frame_match

  function automatic logic odd_parity(input logic [`SPA_CW-1:0] w);
    return ~(^w);
  endfunction : odd_parity

  // ============================================================
  // State

  spa_dev_state_t q;
  spa_dev_state_t d;

  spa_tri_t                  cksel;
  logic                      rate;
  logic                      rx_clock_rate_select;
  spa_tri_t                  par_ctl;
  spa_tri_t                  fchar;
  logic [`SPA_NCH-1:0]       rfen;
  logic                      ref_rise;
  logic                      armed;
  logic                      bypass;
  logic                      halfref;
  logic                      toggle;
  logic                      update;
  logic [2:0]                rx_half;
  logic [2*`SPA_CW-1:0]      window;
  logic [3:0]                off;
  logic [`SPA_CW-1:0]        word;

  always_comb begin
    d = q;
    window = '0;
    off = '0;
    word = '0;

    // Static pins come from the host domain and pass two flops first.
    d.cfg_s1 = link.cfg_pins;
    d.cfg_s2 = q.cfg_s1;
    cksel   = spa_tri_t'(q.cfg_s2[`SPA_CFG_CKSEL_LSB +: 2]);
    rate    = q.cfg_s2[`SPA_CFG_RATE_BIT];
    rx_clock_rate_select  = q.cfg_s2[`SPA_CFG_RX_CLOCK_RATE_SELECT_BIT];
    par_ctl = spa_tri_t'(q.cfg_s2[`SPA_CFG_PAR_LSB +: 2]);
    fchar   = spa_tri_t'(q.cfg_s2[`SPA_CFG_FCHAR_LSB +: 2]);
    rfen    = q.cfg_s2[`SPA_CFG_RFEN_LSB +: `SPA_NCH];

    // ============================================================
    // Reference clock edge detection and reset sampling
    d.ref_s1 = link.reference_clock_in;
    d.ref_s2 = q.ref_s1;
    d.ref_s3 = q.ref_s2;
    d.rst_s1 = link.tx_phase_align_reset_n;
    d.rst_s2 = q.rst_s1;
    ref_rise = q.ref_s2 && !q.ref_s3;

    if (ref_rise) begin
      if (q.rst_s2) begin
        d.low_cnt = '0;
      end else if (q.low_cnt != 2'd3) begin
        d.low_cnt = q.low_cnt + 2'd1;
      end
    end
    // Low on the second consecutive reference edge starts the reset.
    armed = ref_rise && !q.rst_s2 &&
            (q.low_cnt >= 2'(`SPA_ALIGN_MIN_EDGES - 1));

    bypass  = (cksel == TRI_LOW) && !rate;
    halfref = (cksel == TRI_LOW) && rate;
    d.mult  = rate ? `SPA_MUL_HALF : `SPA_MUL_FULL;
    d.slip  = 1'b0;

    // ============================================================
    // Phase-align buffer control
    case (q.align)
      AL_BYPASS: begin
        if (!bypass) begin
          d.align = AL_LOCK;
        end
      end
      AL_LOCK: begin
        if (bypass) begin
          d.align = AL_BYPASS;
        end else if (armed && halfref) begin
          d.fault = 1'b0;
        end else if (armed) begin
          d.align = AL_RETUNE;
          d.phase = q.phase + 4'd1;
          d.slip  = 1'b1;
        end
      end
      AL_RETUNE: begin
        if (bypass) begin
          d.align = AL_BYPASS;
        end else if (ref_rise && q.rst_s2) begin
          d.align = AL_LOCK;
        end else if (ref_rise) begin
          d.phase = q.phase + 4'd1;
          d.slip  = 1'b1;
        end
      end
      default: begin
        d.align = AL_BYPASS;
      end
    endcase
    // A fault reported while it is cleared still stands.
    if (tx_buffer_fault_in && halfref) begin
      d.fault = 1'b1;
    end

    // ============================================================
    // Recovered clock divider
    rx_half = rx_clock_rate_select ? `SPA_RX_HALF_HALF : `SPA_RX_HALF_FULL;
    toggle  = q.rx_div >= rx_half - 3'd1;
    d.rx_div = toggle ? 3'd0 : q.rx_div + 3'd1;
    if (toggle) begin
      d.rclk = !q.rclk;
    end
    // Half rate updates on both true and complement rising edges.
    update = toggle && (rx_clock_rate_select || !q.rclk);
    d.take = update;

    // ============================================================
    // Framer and output register
    for (int c = 0; c < `SPA_NCH; c++) begin
      if (update) begin
        window = {q.prev[c], rx_raw_chars[c]};
        off = q.offset[c];
        if (rfen[c]) begin
          for (int k = `SPA_CW - 1; k >= 0; k--) begin
            if (frame_match(window[2*`SPA_CW-1-k -: `SPA_CW], fchar)) begin
              off = 4'(k);
            end
          end
        end
        word = window[5'(2*`SPA_CW-1) - 5'(off) -: `SPA_CW];
        d.prev[c]   = rx_raw_chars[c];
        d.offset[c] = off;
        d.data[c]   = word;
        d.flag[c]   = frame_match(word, fchar);
        d.par[c]    = odd_parity(word);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ============================================================
  // Outputs
  always_comb begin
    for (int c = 0; c < `SPA_NCH; c++) begin
      link.recovered_char_clock_pair_t[c] = q.rclk;
      link.recovered_char_clock_pair_c[c] = !q.rclk;
      link.rx_odd_parity_oe[c] = par_ctl != TRI_LOW;
    end
  end

  assign link.rx_data_word           = q.data;
  assign link.frame_char_detect_flag = q.flag;
  assign link.rx_odd_parity_out      = q.par;
  assign rx_raw_take                 = q.take;
  assign tx_aligned           = q.align != AL_RETUNE;
  assign tx_char_slip         = q.slip;
  assign tx_phase_offset      = q.phase;
  assign tx_buffer_fault_flag = q.fault;
  assign tx_pll_multiplier    = q.mult;

endmodule : spa_dev

// ==== rtl/spa_host.sv ====
// Host end: makes the reference clock, sequences the phase-align reset,
// drives the static selects and captures received words into a FIFO.
// Assumes init_start is given after the transceiver's test reset cycle.
`include "spa_regs.svh"

module spa_host
  import spa_pkg::*;
(
  input  wire logic                        core_clk,
  input  wire logic                        reset,
  spa_link_if.host                         link,
  input  wire logic [`SPA_CFG_W-1:0]       cfg_in,
  input  wire logic                        init_start,
  input  wire logic                        tx_clock_valid,
  output logic                             init_done,
  output logic                             out_valid,
  input  wire logic                        out_ready,
  output logic [`SPA_FIFO_W-1:0]           out_word,
  output logic                             capture_overrun
);

  spa_host_state_t        q;
  spa_host_state_t        d;
  logic                   ref_rise;
  logic                   push;
  logic                   in_ready;
  logic                   t_rise;
  logic                   c_rise;

  always_comb begin
    d = q;

    // ============================================================
    // Reference clock divider
    ref_rise = 1'b0;
    if (q.ref_div >= `SPA_REF_HALF - 3'd1) begin
      d.ref_div = '0;
      d.ref_clk = !q.ref_clk;
      ref_rise  = !q.ref_clk;
    end else begin
      d.ref_div = q.ref_div + 3'd1;
    end

    // ============================================================
    // Initialisation sequence
    // The reset is pulsed in bypass as well; the transceiver ignores it.
    case (q.st)
      H_IDLE: begin
        d.rst_n = 1'b1;
        if (init_start && tx_clock_valid) begin
          d.st  = H_LOCK;
          d.cnt = 16'(`SPA_TX_LOCK_CYC);
        end
      end
      H_LOCK: begin
        if (q.cnt != 16'd0) begin
          d.cnt = q.cnt - 16'd1;
        end else begin
          d.st    = H_PULSE;
          d.rst_n = 1'b0;
          d.edges = '0;
        end
      end
      H_PULSE: begin
        if (ref_rise) begin
          d.edges = q.edges + 2'd1;
          if (q.edges == `SPA_PULSE_EDGES - 2'd1) begin
            d.st    = H_DONE;
            d.rst_n = 1'b1;
          end
        end
      end
      H_DONE: begin
        d.rst_n = 1'b1;
        if (init_start) begin
          d.st = H_IDLE;
        end
      end
      default: begin
        d.st = H_IDLE;
      end
    endcase

    // ============================================================
    // Receive capture, all pins synchronised first
    d.t_s1 = link.recovered_char_clock_pair_t[0];
    d.t_s2 = q.t_s1;
    d.t_s3 = q.t_s2;
    d.c_s1 = link.recovered_char_clock_pair_c[0];
    d.c_s2 = q.c_s1;
    d.c_s3 = q.c_s2;
    d.w_s1 = {link.frame_char_detect_flag,
              link.rx_odd_parity_out & link.rx_odd_parity_oe,
              link.rx_data_word};
    d.w_s2 = q.w_s1;
    t_rise = q.t_s2 && !q.t_s3;
    c_rise = q.c_s2 && !q.c_s3;
    if (cfg_in[`SPA_CFG_RX_CLOCK_RATE_SELECT_BIT]) begin
      push = t_rise || c_rise;
    end else begin
      push = t_rise;
    end
    if (push && !in_ready) begin
      d.overrun = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      q <= '{st: H_IDLE, rst_n: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  spa_fifo #(
    .W (`SPA_FIFO_W),
    .D (`SPA_FIFO_DEPTH)
  ) spa_fifo_i (
    .core_clk  (core_clk),
    .reset     (reset),
    .in_valid  (push),
    .in_ready  (in_ready),
    .in_data   (q.w_s2),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_word)
  );

  assign link.reference_clock_in     = q.ref_clk;
  assign link.tx_phase_align_reset_n = q.rst_n;
  assign link.cfg_pins               = cfg_in;
  assign init_done                   = q.st == H_DONE;
  assign capture_overrun             = q.overrun;

endmodule : spa_host

// ==== test/spa_link_monitor.sv ====
// Concurrent checks on the pins between the transceiver and host ends.
// Assumes the bench instantiates it beside spa_link_if on the core clock.
`include "spa_regs.svh"

module spa_link_monitor (
  input wire logic                             core_clk,
  input wire logic                             reset,
  input wire logic                             reference_clock_in,
  input wire logic                             tx_phase_align_reset_n,
  input wire logic [`SPA_CFG_W-1:0]            cfg_pins,
  input wire logic [`SPA_NCH-1:0][`SPA_CW-1:0] rx_data_word,
  input wire logic [`SPA_NCH-1:0]              frame_char_detect_flag,
  input wire logic [`SPA_NCH-1:0]              rx_odd_parity_out,
  input wire logic [`SPA_NCH-1:0]              rx_odd_parity_oe,
  input wire logic [`SPA_NCH-1:0]              recovered_char_clock_pair_t,
  input wire logic [`SPA_NCH-1:0]              recovered_char_clock_pair_c
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int LOCK_CYC = `SPA_TX_LOCK_CYC;
  logic        ref_q;
  logic [1:0]  low_edges_q;
  logic [10:0] since_q;

  // ============================================================
  // Helper counters
  // Reference rises seen while the align reset is low, saturating.
  always_ff @(posedge core_clk) begin
    ref_q <= reference_clock_in;
    if (reset || tx_phase_align_reset_n)
      low_edges_q <= 2'h0;
    else if (reference_clock_in && !ref_q && low_edges_q != 2'h3)
      low_edges_q <= low_edges_q + 2'h1;
    if (reset)
      since_q <= 11'h0;
    else if (since_q != 11'h7ff)
      since_q <= since_q + 11'h1;
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence rise_s; $rose(recovered_char_clock_pair_t[0]); endsequence
  sequence upd_s; $changed(recovered_char_clock_pair_t[0]); endsequence

  clk_pair_a: assert property (
    recovered_char_clock_pair_t == ~recovered_char_clock_pair_c)
    else $error("recovered clocks not complementary");
  full_rate_a: assert property (
    (!cfg_pins[3] and rise_s) |-> ##4 rise_s)
    else $error("full rate clock period wrong");
  half_rate_a: assert property (
    (cfg_pins[3] and upd_s) |=> $stable(recovered_char_clock_pair_t)[*3]
      ##1 upd_s)
    else $error("half rate clock toggle spacing wrong");
  data_edge_a: assert property (
    $changed(rx_data_word) |-> upd_s and
      (cfg_pins[3] || recovered_char_clock_pair_t[0]))
    else $error("data changed off the selected clock edge");
  together_a: assert property (
    $changed(frame_char_detect_flag) || $changed(rx_odd_parity_out)
      |-> upd_s)
    else $error("flag or parity changed apart from data");
  oe_off_a: assert property (
    (cfg_pins[5:4] == 2'h0)[*3] |-> rx_odd_parity_oe == 4'h0)
    else $error("parity drivers on with parity off");
  oe_on_a: assert property (
    (cfg_pins[5:4] != 2'h0)[*3] |-> rx_odd_parity_oe == 4'hf)
    else $error("parity drivers off with parity on");
  rst_hold_a: assert property (
    $rose(tx_phase_align_reset_n) |-> low_edges_q >= 2'h2)
    else $error("align reset released too early");
  lock_wait_a: assert property (
    $fell(tx_phase_align_reset_n) |-> since_q >= LOCK_CYC)
    else $error("align reset before lock time");
  for (genvar c = 0; c < `SPA_NCH; c++) begin : g_ch
    odd_par_a: assert property (
      rx_odd_parity_oe[c] && $changed(rx_data_word[c])
        |-> rx_odd_parity_out[c] == ~^rx_data_word[c])
      else $error("parity does not match data");
    flag_a: assert property (
      $changed(rx_data_word[c]) && cfg_pins[7:6] == 2'h2 |->
        frame_char_detect_flag[c] == (rx_data_word[c] == `SPA_K285_NEG
        || rx_data_word[c] == ~`SPA_K285_NEG))
      else $error("frame flag does not match data");
  end
endmodule : spa_link_monitor

// ==== test/serdes_phase_align_rx_output_tb.sv ====
// Self-checking bench joining the transceiver and host ends.
// Assumes the design files and spa_link_monitor are compiled first.
`include "spa_regs.svh"

`define CHK(what, exp, got) \
  begin \
    check_count++; \
    if ((got) !== (exp)) begin \
      fail_count++; \
      $display("Error %s expected %0h seen %0h", what, exp, got); \
    end \
  end

module serdes_phase_align_rx_output_tb import spa_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic                             core_clk;
  logic                             reset;
  logic [`SPA_NCH-1:0][`SPA_CW-1:0] rx_raw_chars;
  logic                             fault_in;
  logic                             tx_aligned;
  logic                             fault_flag;
  logic [4:0]                       mult;
  logic [`SPA_CFG_W-1:0]            cfg_in;
  logic                             init_start;
  logic                             init_done;
  logic                             out_valid;
  logic                             out_ready;
  logic [`SPA_FIFO_W-1:0]           out_word;
  logic                             overrun;
  logic                             saw_retune;
  logic                             saw_slip;
  logic                             slip;
  logic                             clk_valid;
  int                               fail_count;
  int                               check_count;
  int                               cycles;

  spa_link_if spa_link_if_i ();
  spa_dev spa_dev_i (.core_clk(core_clk), .reset(reset),
    .link(spa_link_if_i.dev), .rx_raw_chars(rx_raw_chars),
    .rx_raw_take(), .tx_buffer_fault_in(fault_in),
    .tx_aligned(tx_aligned), .tx_char_slip(slip), .tx_phase_offset(),
    .tx_buffer_fault_flag(fault_flag), .tx_pll_multiplier(mult));
  spa_host spa_host_i (.core_clk(core_clk), .reset(reset),
    .link(spa_link_if_i.host), .cfg_in(cfg_in), .init_start(init_start),
    .tx_clock_valid(clk_valid), .init_done(init_done), .out_valid(out_valid),
    .out_ready(out_ready), .out_word(out_word),
    .capture_overrun(overrun));
  spa_link_monitor spa_link_monitor_i (.core_clk(core_clk),
    .reset(reset),
    .reference_clock_in(spa_link_if_i.reference_clock_in),
    .tx_phase_align_reset_n(spa_link_if_i.tx_phase_align_reset_n),
    .cfg_pins(spa_link_if_i.cfg_pins),
    .rx_data_word(spa_link_if_i.rx_data_word),
    .frame_char_detect_flag(spa_link_if_i.frame_char_detect_flag),
    .rx_odd_parity_out(spa_link_if_i.rx_odd_parity_out),
    .rx_odd_parity_oe(spa_link_if_i.rx_odd_parity_oe),
    .recovered_char_clock_pair_t(
      spa_link_if_i.recovered_char_clock_pair_t),
    .recovered_char_clock_pair_c(
      spa_link_if_i.recovered_char_clock_pair_c));

  // ============================================================
  // Clock, hang guard and retune watcher
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (tx_aligned === 1'b0)
      saw_retune = 1'b1;
    if (slip === 1'b1)
      saw_slip = 1'b1;
    if (cycles == 40000) begin
      fail_count++;
      $display("Error timeout expected finish seen hang");
      stop_test();
    end
  end

  // ============================================================
  // Shared tasks
  task automatic stop_test();
    $display("Comparisons %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : stop_test

  task automatic apply_reset(input spa_tri_t ck, input logic rate,
      input logic rxr, input spa_tri_t par, input spa_tri_t fc);
    cfg_in = {4'h7, fc, par, rxr, rate, ck};
    reset = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 reset = 1'b0;
    repeat (40) @(posedge core_clk);
    #1;
  endtask : apply_reset

  // The align reset and the ref rise after it need slack past done.
  task automatic run_init();
    int n;
    n = 0;
    saw_retune = 1'b0;
    saw_slip = 1'b0;
    init_start = 1'b1;
    @(posedge core_clk);
    #1 init_start = 1'b0;
    while (init_done !== 1'b1 && n < 2000) begin
      @(posedge core_clk);
      #1 n++;
    end
    repeat (40) @(posedge core_clk);
    #1 `CHK("init done", 1'b1, init_done)
  endtask : run_init

  // ============================================================
  // Scenarios
  task automatic test_align();
    apply_reset(TRI_MID, 1'b0, 1'b0, TRI_MID, TRI_HIGH);
    run_init();
    `CHK("retuned", 1'b1, saw_retune)
    `CHK("slipped", 1'b1, saw_slip)
    `CHK("aligned", 1'b1, tx_aligned)
    `CHK("multiplier", `SPA_MUL_FULL, mult)
  endtask : test_align

  task automatic test_bypass();
    apply_reset(TRI_LOW, 1'b0, 1'b0, TRI_MID, TRI_HIGH);
    clk_valid = 1'b0;
    init_start = 1'b1;
    repeat (1100) @(posedge core_clk);
    #1 `CHK("no tx clock", 1'b0, init_done)
    init_start = 1'b0;
    @(posedge core_clk);
    #1 clk_valid = 1'b1;
    run_init();
    `CHK("bypass retune", 1'b0, saw_retune)
    `CHK("bypass slip", 1'b0, saw_slip)
  endtask : test_bypass

  task automatic test_half_ref();
    apply_reset(TRI_LOW, 1'b1, 1'b0, TRI_MID, TRI_HIGH);
    fault_in = 1'b1;
    @(posedge core_clk);
    #1 fault_in = 1'b0;
    repeat (2) @(posedge core_clk);
    #1 `CHK("fault set", 1'b1, fault_flag)
    run_init();
    `CHK("fault cleared", 1'b0, fault_flag)
    `CHK("half ref retune", 1'b0, saw_retune)
    `CHK("multiplier", `SPA_MUL_HALF, mult)
  endtask : test_half_ref

  // Channel 3 has reframing off, so it keeps the rotated character.
  task automatic test_rx(input spa_tri_t fc, input logic rxr,
      input spa_tri_t par);
    logic [`SPA_CW-1:0] d;
    apply_reset(TRI_LOW, 1'b0, rxr, par, fc);
    repeat (200) @(posedge core_clk);
    #1 while (out_valid !== 1'b1) begin
      @(posedge core_clk);
      #1;
    end
    `CHK("oe", (par == TRI_LOW) ? 4'h0 : 4'hf, spa_link_if_i.rx_odd_parity_oe)
    for (int c = 0; c < `SPA_NCH; c++) begin
      d = (c < 3 && fc != TRI_LOW) ? `SPA_K285_NEG : 10'h3d1;
      `CHK("data", d, out_word[c*10 +: 10])
      `CHK("flag", fc != TRI_LOW && d == `SPA_K285_NEG, out_word[44+c])
      `CHK("parity", par != TRI_LOW && ~^d, out_word[40+c])
    end
  endtask : test_rx

  task automatic test_fifo();
    int n;
    n = 0;
    out_ready = 1'b0;
    repeat (200) @(posedge core_clk);
    #1 `CHK("overrun", 1'b1, overrun)
    out_ready = 1'b1;
    repeat (16) begin
      @(posedge core_clk);
      #1 n += (out_valid === 1'b1);
    end
    `CHK("drained", 16, n)
  endtask : test_fifo

  initial begin
    reset = 1'b1;
    cfg_in = 12'h0;
    init_start = 1'b0;
    fault_in = 1'b0;
    clk_valid = 1'b1;
    out_ready = 1'b1;
    rx_raw_chars = {4{10'h3d1}};
    test_align();
    test_bypass();
    test_half_ref();
    test_rx(TRI_LOW, 1'b0, TRI_LOW);
    test_rx(TRI_MID, 1'b1, TRI_MID);
    test_rx(TRI_HIGH, 1'b0, TRI_HIGH);
    test_fifo();
    stop_test();
  end
endmodule : serdes_phase_align_rx_output_tb
